/* rtl/lrp_limit_result_port.sv */
// limit result output port with avalon register slave
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - trigger input passes only while enable high
// - five lines: lo1, hi1, lo2, hi2, master
// - line asserts on boundary hit, releases inside
// - master line is OR of four boundaries
// - activate 10 ms closed, 2 ms open; ten times longer for temperature readings
// - selected active level applies to every line
// - pulse mode: one pulse per failing reading
// - pulse time programmable 1 ms to 99999.999 s
// - in-limit reading ends a running pulse
// - pulse timing independent of reading rate
// - latched master released past control source
// - unlatched master releases when all inside
// - scanning: latch held until next scan
// - enable, pulse, level, latch settings exist
// - one output configuration for whole scan
// - overflow counts as high, never low
module lrp_limit_result_port
  import lrp_pkg::*;
#(
  parameter int DLY_OPEN_P = DLY_OPEN_CYC,
  parameter int DLY_CLOSED_P = DLY_CLOSED_CYC,
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic output_trigger_link,
  input wire lrp_reading_t reading,
  input wire logic control_source_pass,
  input wire logic scan_active,
  input wire logic scan_start,
  input wire logic ext_trigger_in,
  input wire logic trigger_enable_pin,
  output logic ext_trigger_out,
  output logic [4:0] result_line_out,
  output logic [4:0] result_line_oe
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [3:0] ctrl_reg;
  logic [3:0] cfg_scan_reg;
  logic [26:0] pulse_ms_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic ack_reg;
  lrp_cfg_t cfg;
  lrp_state_t state_reg;
  logic [31:0] dly_cnt_reg;
  logic [3:0] pend_reg;
  logic [3:0] bnd_reg;
  logic latch_reg;
  logic pulse_run_reg;
  logic [31:0] pre_cnt_reg;
  logic [26:0] ms_cnt_reg;
  logic [26:0] pulse_len_reg;
  logic [3:0] hits;
  logic [31:0] dly_load;
  logic apply;
  logic ms_tick;
  logic pulse_done;
  logic latch_clear;
  logic master_on;
  logic [4:0] asserted;
  logic wr_en;
  logic [2:0] events;
  logic [26:0] pulse_wr;

  assign cfg = lrp_cfg_t'(scan_active ? cfg_scan_reg : ctrl_reg);
  assign hits = boundary_hits(reading);
  assign apply = (state_reg == ST_DELAY) && (dly_cnt_reg == 32'h1);
  assign ms_tick = pulse_run_reg && (pre_cnt_reg == 32'(CYC_PER_MS_P - 1));
  assign pulse_done = ms_tick && ((ms_cnt_reg + 27'h1) >= pulse_len_reg);
  assign latch_clear = scan_active ? scan_start : control_source_pass;

  // ****************************************************************
  // avalon slave, one wait state per access
  // ****************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_en = avs_write && ack_reg;
  assign pulse_wr = avs_writedata[26:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        OFF_CTRL: avs_readdata <= {28'h0000000, ctrl_reg};
        OFF_PULSE: avs_readdata <= {5'h00, pulse_ms_reg};
        OFF_STATUS: avs_readdata <= {25'h0000000, (state_reg == ST_DELAY),
                                     latch_reg, asserted};
        OFF_IRQ_STAT: avs_readdata <= {29'h00000000, irq_stat_reg};
        OFF_IRQ_MASK: avs_readdata <= {29'h00000000, irq_mask_reg};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      irq_mask_reg <= IRQ_RST;
      pulse_ms_reg <= PULSE_MS_RST;
    end else if (wr_en) begin
      if (avs_address == OFF_CTRL) begin
        ctrl_reg <= avs_writedata[3:0];
      end
      if (avs_address == OFF_IRQ_MASK) begin
        irq_mask_reg <= avs_writedata[2:0];
      end
      if (avs_address == OFF_PULSE) begin
        if (avs_writedata[31:27] != 5'h00 || pulse_wr > PULSE_MS_MAX) begin
          pulse_ms_reg <= PULSE_MS_MAX;
        end else if (pulse_wr < PULSE_MS_MIN) begin
          pulse_ms_reg <= PULSE_MS_MIN;
        end else begin
          pulse_ms_reg <= pulse_wr;
        end
      end
    end
  end

  // settings frozen for the duration of a scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_scan_reg <= CTRL_RST;
    end else if (scan_start || !scan_active) begin
      cfg_scan_reg <= ctrl_reg;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign events[IRQ_FAIL_BIT] = output_trigger_link && (hits != 4'h0);
  assign events[IRQ_LATCH_BIT] = apply && cfg.master_result_latch &&
                                 (pend_reg != 4'h0) && !latch_reg;
  assign events[IRQ_PEND_BIT] = pulse_done;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= IRQ_RST;
    end else if (wr_en && avs_address == OFF_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata[2:0]) | events;
    end else begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // activation delay after the output trigger
  // ****************************************************************
  always_comb begin
    dly_load = reading.channel_closed ? 32'(DLY_CLOSED_P) : 32'(DLY_OPEN_P);
    if (reading.temperature) begin
      dly_load = 32'(dly_load * TEMP_FACTOR);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      dly_cnt_reg <= 32'h00000000;
      pend_reg <= 4'h0;
    end else if (output_trigger_link) begin
      pend_reg <= hits;
      dly_cnt_reg <= dly_load;
      state_reg <= (hits != 4'h0) ? ST_DELAY : ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          dly_cnt_reg <= 32'h00000000;
        end
        ST_DELAY: begin
          dly_cnt_reg <= dly_cnt_reg - 32'h1;
          if (dly_cnt_reg == 32'h1) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // boundary lines
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bnd_reg <= 4'h0;
    end else if (output_trigger_link) begin
      bnd_reg <= bnd_reg & hits;
    end else if (apply) begin
      bnd_reg <= bnd_reg | pend_reg;
    end else if (pulse_done && cfg.pulse_mode) begin
      bnd_reg <= 4'h0;
    end
  end

  // ****************************************************************
  // pulse timer, free of the measurement path
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_run_reg <= 1'b0;
      pre_cnt_reg <= 32'h00000000;
      ms_cnt_reg <= 27'h0000000;
      pulse_len_reg <= PULSE_MS_RST;
    end else if (apply) begin
      pulse_run_reg <= cfg.pulse_mode;
      pre_cnt_reg <= 32'h00000000;
      ms_cnt_reg <= 27'h0000000;
      pulse_len_reg <= pulse_ms_reg;
    end else if (pulse_done) begin
      pulse_run_reg <= 1'b0;
    end else if (pulse_run_reg) begin
      if (ms_tick) begin
        pre_cnt_reg <= 32'h00000000;
        ms_cnt_reg <= ms_cnt_reg + 27'h1;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 32'h1;
      end
    end
  end

  // ****************************************************************
  // master line and latch
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else if (apply && cfg.master_result_latch && pend_reg != 4'h0) begin
      latch_reg <= 1'b1;
    end else if (latch_clear || !cfg.master_result_latch) begin
      latch_reg <= 1'b0;
    end
  end

  assign master_on = (|bnd_reg) || latch_reg;
  assign asserted = cfg.result_output_enable ?
                    {master_on, bnd_reg} : 5'h00;

  // ****************************************************************
  // pins: open collector, pulled up outside
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_line_oe <= 5'h1F;
      ext_trigger_out <= 1'b0;
    end else begin
      result_line_oe <= ~(asserted ^ {LINES{cfg.active_level_select}});
      ext_trigger_out <= ext_trigger_in && trigger_enable_pin;
    end
  end
  assign result_line_out = 5'h00;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence fail_trig_s;
    output_trigger_link && hits != 4'h0 && !reading.temperature &&
    !reading.channel_closed;
  endsequence
  sequence load_s;
    state_reg == ST_DELAY && dly_cnt_reg == 32'(DLY_OPEN_P);
  endsequence

  trig_gate_a: assert property (
    ext_trigger_out == $past(ext_trigger_in && trigger_enable_pin))
    else $error("trigger gate wrong");
  delay_load_a: assert property (
    fail_trig_s |=> load_s)
    else $error("activation delay wrong");
  pass_release_a: assert property (
    output_trigger_link && hits == 4'h0 |=> bnd_reg == 4'h0)
    else $error("in-limit reading left a line set");
  master_or_a: assert property (
    cfg.result_output_enable && !cfg.active_level_select && !latch_reg |=>
    result_line_oe[4] == (&result_line_oe[3:0]))
    else $error("master not OR of boundaries");
  level_sel_a: assert property (
    $stable(asserted) && $stable(cfg.active_level_select) |=>
    result_line_oe ==
    ~($past(asserted) ^ {LINES{$past(cfg.active_level_select)}}))
    else $error("active level wrong");
  pulse_end_a: assert property (
    pulse_done && cfg.pulse_mode && !output_trigger_link && !apply |=>
    bnd_reg == 4'h0)
    else $error("pulse not ended");
  pulse_range_a: assert property (
    pulse_ms_reg >= PULSE_MS_MIN && pulse_ms_reg <= PULSE_MS_MAX)
    else $error("pulse time out of range");
  latch_hold_a: assert property (
    latch_reg && cfg.master_result_latch && !latch_clear |=> latch_reg)
    else $error("latched master released early");
  disable_a: assert property (
    !cfg.result_output_enable |=>
    result_line_oe == ~{LINES{$past(cfg.active_level_select)}})
    else $error("disabled output asserted");
  overflow_a: assert property (
    reading.overflow |-> hits == 4'hA)
    else $error("overflow counted as low");

endmodule // lrp_limit_result_port

`default_nettype wire

/* rtl/lrp_pkg.sv */
// constants, types and decode function for the limit result output port
package lrp_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_KHZ = 250000;
  localparam int DLY_OPEN_MS = 2;
  localparam int DLY_CLOSED_MS = 10;
  localparam int PULSE_TICK_MS = 1;
  localparam int TEMP_FACTOR = 10;
  localparam int DLY_OPEN_CYC = DLY_OPEN_MS * CLK_KHZ;
  localparam int DLY_CLOSED_CYC = DLY_CLOSED_MS * CLK_KHZ;
  localparam int CYC_PER_MS = PULSE_TICK_MS * CLK_KHZ;

  // ****************************************************************
  // pulse time, in milliseconds
  // ****************************************************************
  localparam int PULSE_W = 27;
  localparam logic [26:0] PULSE_MS_MIN = 27'h0000001;
  localparam logic [26:0] PULSE_MS_MAX = 27'h5F5E0FF;
  localparam logic [26:0] PULSE_MS_RST = 27'h0000002;

  // ****************************************************************
  // register map, byte offsets
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_PULSE = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int LINES = 5;
  localparam int ST_LATCH_BIT = 5;
  localparam int ST_PEND_BIT = 6;
  localparam int IRQ_W = 3;
  localparam int IRQ_FAIL_BIT = 0;
  localparam int IRQ_LATCH_BIT = 1;
  localparam int IRQ_PEND_BIT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic overflow;
    logic channel_closed;
    logic temperature;
    logic second_high_boundary;
    logic second_low_boundary;
    logic first_high_boundary;
    logic first_low_boundary;
  } lrp_reading_t;

  typedef struct packed {
    logic master_result_latch;
    logic active_level_select;
    logic pulse_mode;
    logic result_output_enable;
  } lrp_cfg_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DELAY = 1'b1
  } lrp_state_t;

  // boundary hits, bit 0 = line one; overflow reads as positive
  function automatic logic [3:0] boundary_hits(input lrp_reading_t r);
    logic [3:0] h;
    h = {r.second_high_boundary, r.second_low_boundary,
         r.first_high_boundary, r.first_low_boundary};
    if (r.overflow) begin
      h = 4'hA;
    end
    return h;
  endfunction

endpackage

/* tb/lrp_pin_load.sv */
// pin load model: pull-ups on result lines, trigger enable pin
`timescale 1ns/100ps
`default_nettype none
module lrp_pin_load (
  input wire logic [4:0] line_out,
  input wire logic [4:0] line_oe,
  input wire logic enable_pull_low,
  output logic [4:0] pin_level,
  output logic trigger_enable_pin
);
  // open collector pins pulled up when released
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_level[i] = line_oe[i] ? line_out[i] : 1'h1;
    end
  end
  // open enable pin reads high
  assign trigger_enable_pin = enable_pull_low ? 1'h0 : 1'h1;
endmodule // lrp_pin_load
`default_nettype wire

/* tb/tb_limit_result_output_port.sv */
// testbench for the limit result output port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_limit_result_output_port
  import lrp_pkg::*;
;
  localparam int DO = 20;
  localparam int DC = 50;
  localparam int CM = 10;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest, irq, ext_trigger_out, trigger_enable_pin;
  logic output_trigger_link = 1'h0;
  lrp_reading_t reading = '0;
  logic control_source_pass = 1'h0;
  logic scan_active = 1'h0;
  logic scan_start = 1'h0;
  logic ext_trigger_in = 1'h0;
  logic en_low = 1'h0;
  logic [4:0] result_line_out, result_line_oe, pins;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  lrp_limit_result_port #(.DLY_OPEN_P(DO), .DLY_CLOSED_P(DC),
    .CYC_PER_MS_P(CM)) dut (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .output_trigger_link(output_trigger_link), .reading(reading),
    .control_source_pass(control_source_pass), .scan_active(scan_active),
    .scan_start(scan_start), .ext_trigger_in(ext_trigger_in),
    .trigger_enable_pin(trigger_enable_pin),
    .ext_trigger_out(ext_trigger_out), .result_line_out(result_line_out),
    .result_line_oe(result_line_oe));
  lrp_pin_load load (.line_out(result_line_out), .line_oe(result_line_oe),
    .enable_pull_low(en_low), .pin_level(pins),
    .trigger_enable_pin(trigger_enable_pin));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // bus and pin tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [4:0] e);
    @(negedge clk);
    `CHK(nm, e, pins)
    @(posedge clk);
  endtask
  task automatic see(input string nm, input logic e, ref logic g);
    @(negedge clk);
    `CHK(nm, e, g)
    @(posedge clk);
  endtask
  task automatic pulse(input logic sel);
    if (sel) begin
      scan_start <= 1'h1;
    end else begin
      control_source_pass <= 1'h1;
    end
    @(posedge clk);
    scan_start <= 1'h0;
    control_source_pass <= 1'h0;
    cyc(2);
  endtask
  task automatic trig(input logic [6:0] r);
    reading <= r;
    output_trigger_link <= 1'h1;
    @(posedge clk);
    output_trigger_link <= 1'h0;
  endtask
  task automatic fail_at(input int d, input logic [6:0] r,
                         input logic [4:0] b, input logic [4:0] e);
    trig(r);
    cyc(d - 3);
    chk("pins early", b);
    cyc(3);
    chk("pins late", e);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk("pins reset", 5'h00);
    bus(1'h0, OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    bus(1'h0, OFF_PULSE, 32'h0);
    `CHK("pulse", 32'h2, rd)
    bus(1'h0, 5'h14, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  task automatic t_level();
    bus(1'h1, OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      fail_at(DO, 7'h01 << i, 5'h00, 5'h10 | (5'h01 << i));
      trig(7'h00);
      cyc(2);
      chk("in limit", 5'h00);
    end
    fail_at(DC, 7'h28, 5'h00, 5'h18);
    trig(7'h00);
    fail_at(DO * 10, 7'h12, 5'h00, 5'h12);
    trig(7'h00);
    fail_at(DO, 7'h41, 5'h00, 5'h1A);
    bus(1'h1, OFF_CTRL, 32'h0);
    chk("disabled", 5'h00);
    trig(7'h00);
  endtask
  task automatic t_low();
    bus(1'h1, OFF_CTRL, 32'h5);
    chk("low idle", 5'h1F);
    fail_at(DO, 7'h02, 5'h1F, 5'h0D);
    trig(7'h00);
    cyc(2);
    chk("low in", 5'h1F);
    bus(1'h1, OFF_CTRL, 32'h0);
  endtask
  task automatic t_pulse();
    bus(1'h1, OFF_CTRL, 32'h3);
    bus(1'h1, OFF_PULSE, 32'h1);
    fail_at(DO, 7'h04, 5'h00, 5'h14);
    cyc(4);
    chk("pulse on", 5'h14);
    cyc(6);
    chk("pulse off", 5'h00);
    bus(1'h0, OFF_IRQ_STAT, 32'h0);
    `CHK("pulse irq", 32'h5, rd)
    bus(1'h1, OFF_IRQ_STAT, 32'h7);
    bus(1'h1, OFF_PULSE, 32'h64);
    fail_at(DO, 7'h04, 5'h00, 5'h14);
    trig(7'h00);
    cyc(2);
    chk("pulse cut", 5'h00);
    bus(1'h1, OFF_PULSE, 32'h0);
    bus(1'h0, OFF_PULSE, 32'h0);
    `CHK("pulse min", 32'h1, rd)
    bus(1'h1, OFF_PULSE, 32'h05F5E100);
    bus(1'h0, OFF_PULSE, 32'h0);
    `CHK("pulse max", 32'h05F5E0FF, rd)
    bus(1'h1, OFF_CTRL, 32'h0);
  endtask
  task automatic t_latch();
    bus(1'h1, OFF_CTRL, 32'h9);
    fail_at(DO, 7'h01, 5'h00, 5'h11);
    trig(7'h00);
    cyc(2);
    chk("held", 5'h10);
    bus(1'h0, OFF_IRQ_STAT, 32'h0);
    `CHK("latch irq", 32'h3, rd)
    pulse(1'h0);
    chk("freed", 5'h00);
    scan_active <= 1'h1;
    pulse(1'h1);
    bus(1'h1, OFF_CTRL, 32'hD);
    fail_at(DO, 7'h02, 5'h00, 5'h12);
    trig(7'h00);
    pulse(1'h0);
    chk("scan held", 5'h10);
    pulse(1'h1);
    chk("next scan", 5'h1F);
    scan_active <= 1'h0;
    bus(1'h1, OFF_CTRL, 32'h0);
  endtask
  task automatic t_irq();
    bus(1'h1, OFF_IRQ_STAT, 32'h7);
    bus(1'h1, OFF_IRQ_MASK, 32'h1);
    bus(1'h1, OFF_CTRL, 32'h1);
    trig(7'h01);
    cyc(DO + 4);
    see("irq set", 1'h1, irq);
    bus(1'h0, OFF_STATUS, 32'h0);
    `CHK("status", 32'h11, rd)
    bus(1'h0, OFF_IRQ_STAT, 32'h0);
    `CHK("irq stat", 32'h1, rd)
    bus(1'h1, OFF_IRQ_MASK, 32'h0);
    see("irq masked", 1'h0, irq);
    bus(1'h1, OFF_IRQ_MASK, 32'h1);
    see("irq unmask", 1'h1, irq);
    bus(1'h1, OFF_IRQ_STAT, 32'h1);
    see("irq clear", 1'h0, irq);
    bus(1'h1, OFF_CTRL, 32'h0);
  endtask
  task automatic t_trig();
    ext_trigger_in <= 1'h1;
    cyc(3);
    see("trig open", 1'h1, ext_trigger_out);
    en_low <= 1'h1;
    cyc(3);
    see("trig off", 1'h0, ext_trigger_out);
    en_low <= 1'h0;
    ext_trigger_in <= 1'h0;
  endtask

  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    cyc(16);
    resetn <= 1'h1;
    cyc(4);
    t_reset();
    t_level();
    t_low();
    t_pulse();
    t_latch();
    t_irq();
    t_trig();
    report_and_stop();
  end
endmodule // tb_limit_result_output_port
`default_nettype wire
